//--- rtl/itc_pkg.sv
// Constants, types and op codes for the interrupt and timer control instruction unit
//
// Contract
// (RULE1) Disable-interrupts op writes 0 to the global interrupt enable flag.
// (RULE2) Enable-interrupts op writes 1 to the global interrupt enable flag.
// (RULE3) Ext-0 flag test: mask bit 0 clear, set flag is cleared and skips; else no-op.
// (RULE4) Ext-1 flag test: mask bit 1 clear, set flag is cleared and skips; else no-op.
// (RULE5) Ext-0 pin test with polarity bit 0 skips on low pin, runs on high.
// (RULE6) Ext-0 pin test with polarity bit 1 skips on high pin, runs on low.
// (RULE7) Ext-1 pin test with polarity bit 0 skips on low pin, runs on high.
// (RULE8) Ext-1 pin test with polarity bit 1 skips on high pin, runs on low.
// (RULE9) Ops move first interrupt control register to and from accumulator, carry untouched.
// (RULE10) Ops move second interrupt control register to and from accumulator.
// (RULE11) Ops move first interrupt pin control register to and from accumulator.
// (RULE12) Ops move second interrupt pin control register to and from accumulator.
// (RULE13) Write-only op copies accumulator bits 1:0 into timer aux control register.
// (RULE14) Ops move first timer control register to and from accumulator.
// (RULE15) Ops move second timer control register to and from accumulator.
// (RULE16) Ops move third timer control register to and from accumulator.
// (RULE17) Ops move fifth timer control register to and from accumulator.
// (RULE18) Each op takes one cycle; a skipped op is accepted but has no effect.
// (RULE19) Accumulator and control registers are 4 bits, moved unchanged in parallel; the code keeps the timer aux control register at 2 bits.
package itc_pkg;

  // Data widths
  localparam int ACC_W = 4;
  localparam int AUX_W = 2;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int EV_W  = 4;

  // Reset values
  localparam logic [ACC_W-1:0] CTRL_RST = 4'h0;
  localparam logic [AUX_W-1:0] AUX_RST  = 2'h0;
  localparam logic [EV_W-1:0]  EV_RST   = 4'h0;

  // Control bit positions
  localparam int EXT0_MASK_POS = 0;
  localparam int EXT1_MASK_POS = 1;
  localparam int POL_POS       = 2;

  // Register offsets (byte addresses)
  localparam logic [WB_AW-1:0] ADDR_STATE = 8'h00;
  localparam logic [WB_AW-1:0] ADDR_ISTAT = 8'h04;
  localparam logic [WB_AW-1:0] ADDR_IMASK = 8'h08;
  localparam logic [WB_AW-1:0] ADDR_IREGS = 8'h0C;
  localparam logic [WB_AW-1:0] ADDR_TREGS = 8'h10;

  // Event bit positions in status and mask
  localparam int EV_EXT0 = 0;
  localparam int EV_EXT1 = 1;
  localparam int EV_SKIP = 2;
  localparam int EV_SUPP = 3;

  // Operations issued by the sequencer
  typedef enum logic [4:0] {
    OP_NOP       = 5'h00,
    OP_IRQ_DIS   = 5'h01,
    OP_IRQ_EN    = 5'h02,
    OP_TST_FLG0  = 5'h03,
    OP_TST_FLG1  = 5'h04,
    OP_TST_PIN0  = 5'h05,
    OP_TST_PIN1  = 5'h06,
    OP_RD_ICA    = 5'h07,
    OP_WR_ICA    = 5'h08,
    OP_RD_ICB    = 5'h09,
    OP_WR_ICB    = 5'h0A,
    OP_RD_IPA    = 5'h0B,
    OP_WR_IPA    = 5'h0C,
    OP_RD_IPB    = 5'h0D,
    OP_WR_IPB    = 5'h0E,
    OP_WR_AUX    = 5'h0F,
    OP_RD_TCA    = 5'h10,
    OP_WR_TCA    = 5'h11,
    OP_RD_TCB    = 5'h12,
    OP_WR_TCB    = 5'h13,
    OP_RD_TCC    = 5'h14,
    OP_WR_TCC    = 5'h15,
    OP_RD_TCE    = 5'h16,
    OP_WR_TCE    = 5'h17
  } itc_op_t;

  // Execution state: next op runs or is suppressed
  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_SKIP = 1'b1
  } itc_state_t;

  // Instruction request from the sequencer
  typedef struct packed {
    logic              valid;
    itc_op_t           op;
    logic [ACC_W-1:0]  acc;
  } itc_instr_t;

  // Interrupt control registers
  typedef struct packed {
    logic [ACC_W-1:0] irq_ctrl_reg_a;
    logic [ACC_W-1:0] irq_ctrl_reg_b;
    logic [ACC_W-1:0] irq_pin_ctrl_reg_a;
    logic [ACC_W-1:0] irq_pin_ctrl_reg_b;
  } itc_irq_regs_t;

  // Timer control registers
  typedef struct packed {
    logic [AUX_W-1:0] timer_aux_ctrl_reg;
    logic [ACC_W-1:0] timer_ctrl_reg_a;
    logic [ACC_W-1:0] timer_ctrl_reg_b;
    logic [ACC_W-1:0] timer_ctrl_reg_c;
    logic [ACC_W-1:0] timer_ctrl_reg_e;
  } itc_tmr_regs_t;

endpackage : itc_pkg

//--- rtl/itc_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module itc_sync #(
  parameter int W      = 2,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage_reg [STAGES];

  // Refuse a chain too short to settle metastability
  if (STAGES < 2) begin : g_bad_stages
    $error("itc_sync needs at least two stages");
  end

  // Shift chain, first stage read only by the second
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STAGES; i++) stage_reg[i] <= '0;
    end else begin
      stage_reg[0] <= async_i;
      for (int i = 1; i < STAGES; i++) stage_reg[i] <= stage_reg[i-1];
    end
  end

  assign sync_o = stage_reg[STAGES-1];

endmodule : itc_sync
`default_nettype wire

//--- rtl/itc_exec.sv
// Execution unit for interrupt and timer control operations with Wishbone view
`timescale 1ns/1ps
`default_nettype none
module itc_exec
  import itc_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // Sequencer request
  input  wire itc_instr_t          instr_i,
  // Answer to sequencer
  output logic     [ACC_W-1:0]     acc_o,
  output logic                     acc_load_o,
  output logic                     skip_o,
  // Request flag set events
  input  wire logic                ext_zero_req_set_i,
  input  wire logic                ext_one_req_set_i,
  // External interrupt pins
  input  wire logic                ext_irq_pin_zero_i,
  input  wire logic                ext_irq_pin_one_i,
  // Flags and control registers to the core
  output logic                     global_irq_enable_flag_o,
  output logic                     ext_zero_request_flag_o,
  output logic                     ext_one_request_flag_o,
  output itc_irq_regs_t            irq_regs_o,
  output itc_tmr_regs_t            tmr_regs_o,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_AW-1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [WB_DW-1:0]    wb_dat_i,
  output logic      [WB_DW-1:0]    wb_dat_o,
  output logic                     wb_ack_o,
  // Interrupt
  output logic                     irq_o
);

  // Skip test on a request flag, gated by its mask bit
  function automatic logic flag_hit(input logic mask_bit, input logic flag);
    flag_hit = !mask_bit && flag;
  endfunction : flag_hit

  // Skip test on a pin level with selectable polarity
  function automatic logic pin_hit(input logic pin, input logic pol);
    pin_hit = pol ? pin : !pin;
  endfunction : pin_hit

  // Sized copy of an 18-bit register view into a wide bus word
  function automatic logic [WB_DW-1:0] widen(input logic [17:0] v);
    widen = {14'h0000, v};
  endfunction : widen

  logic [1:0]       pins_sync;
  itc_state_t       state_reg;
  itc_state_t       state_next;
  logic             run;
  logic             suppress;
  logic             skip_now;
  logic             clr_flag0;
  logic             clr_flag1;
  logic             global_irq_enable_flag_reg;
  logic             flag0_reg;
  logic             flag1_reg;
  itc_irq_regs_t    irq_reg;
  itc_tmr_regs_t    tmr_reg;
  logic [ACC_W-1:0] acc_reg;
  logic             acc_load_reg;
  logic             skip_reg;
  logic [EV_W-1:0]  stat_reg;
  logic [EV_W-1:0]  mask_reg;
  logic [EV_W-1:0]  ev_set;
  logic             ack_reg;
  logic [WB_DW-1:0] rdat_reg;
  logic             wb_req;
  logic             wb_rd_stat;
  logic             wb_wr_mask;

  // Pin levels cross into the core clock
  itc_sync #(
    .W      (2),
    .STAGES (2)
  ) itc_sync_inst (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({ext_irq_pin_one_i, ext_irq_pin_zero_i}),
    .sync_o    (pins_sync)
  );

  // An op runs unless it follows a taken skip
  assign run      = instr_i.valid && (state_reg == ST_EXEC);   // RULE18
  assign suppress = instr_i.valid && (state_reg == ST_SKIP);   // RULE18

  // Skip decision and flag clears for the test ops
  always_comb begin
    skip_now  = 1'b0;
    clr_flag0 = 1'b0;
    clr_flag1 = 1'b0;
    if (run) begin
      case (instr_i.op)
        OP_TST_FLG0: begin
          skip_now  = flag_hit(irq_reg.irq_ctrl_reg_a[EXT0_MASK_POS], flag0_reg); // RULE3
          clr_flag0 = skip_now;                                                    // RULE3
        end
        OP_TST_FLG1: begin
          skip_now  = flag_hit(irq_reg.irq_ctrl_reg_a[EXT1_MASK_POS], flag1_reg); // RULE4
          clr_flag1 = skip_now;                                                    // RULE4
        end
        OP_TST_PIN0: begin
          skip_now = pin_hit(pins_sync[0], irq_reg.irq_pin_ctrl_reg_a[POL_POS]); // RULE5 RULE6
        end
        OP_TST_PIN1: begin
          skip_now = pin_hit(pins_sync[1], irq_reg.irq_pin_ctrl_reg_b[POL_POS]); // RULE7 RULE8
        end
        default: begin
          skip_now = 1'b0;
        end
      endcase
    end
  end

  // Skip sequencing: one suppressed op after a taken skip
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_EXEC: begin
        if (skip_now) state_next = ST_SKIP;   // RULE18
      end
      ST_SKIP: begin
        if (instr_i.valid) state_next = ST_EXEC;   // RULE18
      end
      default: begin
        state_next = ST_EXEC;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  // Global interrupt enable flag
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_irq_enable_flag_reg <= 1'b0;
    end else if (run && instr_i.op == OP_IRQ_DIS) begin
      global_irq_enable_flag_reg <= 1'b0;   // RULE1
    end else if (run && instr_i.op == OP_IRQ_EN) begin
      global_irq_enable_flag_reg <= 1'b1;   // RULE2
    end
  end

  // Request flags: a set in the clearing cycle wins
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag0_reg <= 1'b0;
      flag1_reg <= 1'b0;
    end else begin
      flag0_reg <= ext_zero_req_set_i || (flag0_reg && !clr_flag0);   // RULE3
      flag1_reg <= ext_one_req_set_i  || (flag1_reg && !clr_flag1);   // RULE4
    end
  end

  // Interrupt control register loads from the accumulator
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_reg <= {CTRL_RST, CTRL_RST, CTRL_RST, CTRL_RST};
    end else if (run) begin
      case (instr_i.op)
        OP_WR_ICA: irq_reg.irq_ctrl_reg_a     <= instr_i.acc;   // RULE9 RULE19
        OP_WR_ICB: irq_reg.irq_ctrl_reg_b     <= instr_i.acc;   // RULE10 RULE19
        OP_WR_IPA: irq_reg.irq_pin_ctrl_reg_a <= instr_i.acc;   // RULE11 RULE19
        OP_WR_IPB: irq_reg.irq_pin_ctrl_reg_b <= instr_i.acc;   // RULE12 RULE19
        default: begin
        end
      endcase
    end
  end

  // Timer control register loads from the accumulator
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_reg <= {AUX_RST, CTRL_RST, CTRL_RST, CTRL_RST, CTRL_RST};
    end else if (run) begin
      case (instr_i.op)
        OP_WR_AUX: tmr_reg.timer_aux_ctrl_reg <= instr_i.acc[AUX_W-1:0];   // RULE13
        OP_WR_TCA: tmr_reg.timer_ctrl_reg_a   <= instr_i.acc;   // RULE14 RULE19
        OP_WR_TCB: tmr_reg.timer_ctrl_reg_b   <= instr_i.acc;   // RULE15 RULE19
        OP_WR_TCC: tmr_reg.timer_ctrl_reg_c   <= instr_i.acc;   // RULE16 RULE19
        OP_WR_TCE: tmr_reg.timer_ctrl_reg_e   <= instr_i.acc;   // RULE17 RULE19
        default: begin
        end
      endcase
    end
  end

  // Register reads back to the accumulator, carry never touched
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg      <= CTRL_RST;
      acc_load_reg <= 1'b0;
    end else begin
      acc_load_reg <= 1'b0;
      if (run) begin
        case (instr_i.op)
          OP_RD_ICA: begin
            acc_reg      <= irq_reg.irq_ctrl_reg_a;   // RULE9 RULE19
            acc_load_reg <= 1'b1;
          end
          OP_RD_ICB: begin
            acc_reg      <= irq_reg.irq_ctrl_reg_b;   // RULE10
            acc_load_reg <= 1'b1;
          end
          OP_RD_IPA: begin
            acc_reg      <= irq_reg.irq_pin_ctrl_reg_a;   // RULE11
            acc_load_reg <= 1'b1;
          end
          OP_RD_IPB: begin
            acc_reg      <= irq_reg.irq_pin_ctrl_reg_b;   // RULE12
            acc_load_reg <= 1'b1;
          end
          OP_RD_TCA: begin
            acc_reg      <= tmr_reg.timer_ctrl_reg_a;   // RULE14
            acc_load_reg <= 1'b1;
          end
          OP_RD_TCB: begin
            acc_reg      <= tmr_reg.timer_ctrl_reg_b;   // RULE15
            acc_load_reg <= 1'b1;
          end
          OP_RD_TCC: begin
            acc_reg      <= tmr_reg.timer_ctrl_reg_c;   // RULE16
            acc_load_reg <= 1'b1;
          end
          OP_RD_TCE: begin
            acc_reg      <= tmr_reg.timer_ctrl_reg_e;   // RULE17
            acc_load_reg <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Skip answer, one cycle after the testing op
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      skip_reg <= 1'b0;
    end else begin
      skip_reg <= skip_now;   // RULE18
    end
  end

  // Bus request decode
  assign wb_req     = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_rd_stat = wb_req && !wb_we_i && (wb_adr_i == ADDR_ISTAT);
  assign wb_wr_mask = wb_req && wb_we_i && (wb_adr_i == ADDR_IMASK) && wb_sel_i[0];

  // Events that feed the sticky status
  always_comb begin
    ev_set          = EV_RST;
    ev_set[EV_EXT0] = ext_zero_req_set_i;
    ev_set[EV_EXT1] = ext_one_req_set_i;
    ev_set[EV_SKIP] = skip_now;
    ev_set[EV_SUPP] = suppress;
  end

  // Sticky status, cleared by its read, set wins over the clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_reg <= EV_RST;
    end else if (wb_rd_stat) begin
      stat_reg <= ev_set;
    end else begin
      stat_reg <= stat_reg | ev_set;
    end
  end

  // Interrupt mask, written on the low byte lane
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_reg <= EV_RST;
    end else if (wb_wr_mask) begin
      mask_reg <= wb_dat_i[EV_W-1:0];
    end
  end

  // Bus answer: ack one cycle after the request, read data registered
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= '0;
    end else begin
      ack_reg <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_STATE: rdat_reg <= widen({13'h0000, pins_sync, flag1_reg, flag0_reg, global_irq_enable_flag_reg});
          ADDR_ISTAT: rdat_reg <= widen({14'h0000, stat_reg});
          ADDR_IMASK: rdat_reg <= widen({14'h0000, mask_reg});
          ADDR_IREGS: rdat_reg <= widen({2'h0, irq_reg});
          ADDR_TREGS: rdat_reg <= widen(tmr_reg);
          default:    rdat_reg <= '0;
        endcase
      end
    end
  end

  // Output drive
  assign acc_o                    = acc_reg;
  assign acc_load_o               = acc_load_reg;
  assign skip_o                   = skip_reg;
  assign global_irq_enable_flag_o = global_irq_enable_flag_reg;
  assign ext_zero_request_flag_o  = flag0_reg;
  assign ext_one_request_flag_o   = flag1_reg;
  assign irq_regs_o               = irq_reg;
  assign tmr_regs_o               = tmr_reg;
  assign wb_dat_o                 = rdat_reg;
  assign wb_ack_o                 = ack_reg;
  assign irq_o                    = |(stat_reg & mask_reg);

endmodule : itc_exec
`default_nettype wire

//--- bench/itc_exec_sva.sv
// Concurrent checks on the interrupt and timer control execution unit
`timescale 1ns/1ps
`default_nettype none
module itc_exec_sva
  import itc_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk_i,
  input wire logic             rst_n_i,
  // Sequencer side
  input wire itc_instr_t       instr_i,
  input wire logic [ACC_W-1:0] acc_o,
  input wire logic             acc_load_o,
  input wire logic             skip_o,
  // Pins, flags and registers
  input wire logic             ext_irq_pin_zero_i,
  input wire logic             ext_irq_pin_one_i,
  input wire logic             global_irq_enable_flag_o,
  input wire logic             ext_zero_request_flag_o,
  input wire logic             ext_one_request_flag_o,
  input wire itc_irq_regs_t    irq_regs_o,
  input wire itc_tmr_regs_t    tmr_regs_o
);
  logic       pend_reg;
  logic [1:0] up_reg;
  logic       live;
  logic       ex;
  logic       pins_ok;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Skip stays pending until the next valid op consumes it
  assign live = skip_o | pend_reg;
  assign ex   = instr_i.valid & ~live;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pend_reg <= 1'b0;
    else pend_reg <= live & ~instr_i.valid;
  end
  // Edges since reset, so pin tests are judged only once the synchroniser is full
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  assign pins_ok = (up_reg == 2'h3);
  irq_dis_a: assert property (ex && instr_i.op == OP_IRQ_DIS |=> !global_irq_enable_flag_o)
    else $error("enable flag not cleared");
  irq_en_a: assert property (ex && instr_i.op == OP_IRQ_EN |=> global_irq_enable_flag_o)
    else $error("enable flag not set");
  flag_zero_a: assert property (ex && instr_i.op == OP_TST_FLG0 |=> skip_o ==
    ($past(ext_zero_request_flag_o) && !$past(irq_regs_o.irq_ctrl_reg_a[EXT0_MASK_POS])))
    else $error("flag zero test skip wrong");
  flag_one_a: assert property (ex && instr_i.op == OP_TST_FLG1 |=> skip_o ==
    ($past(ext_one_request_flag_o) && !$past(irq_regs_o.irq_ctrl_reg_a[EXT1_MASK_POS])))
    else $error("flag one test skip wrong");
  pin_zero_a: assert property (ex && instr_i.op == OP_TST_PIN0 && pins_ok &&
    $stable(ext_irq_pin_zero_i) && $past(ext_irq_pin_zero_i, 2) == ext_irq_pin_zero_i
    |=> skip_o == ($past(ext_irq_pin_zero_i) == $past(irq_regs_o.irq_pin_ctrl_reg_a[POL_POS])))
    else $error("pin zero test skip wrong");
  pin_one_a: assert property (ex && instr_i.op == OP_TST_PIN1 && pins_ok &&
    $stable(ext_irq_pin_one_i) && $past(ext_irq_pin_one_i, 2) == ext_irq_pin_one_i
    |=> skip_o == ($past(ext_irq_pin_one_i) == $past(irq_regs_o.irq_pin_ctrl_reg_b[POL_POS])))
    else $error("pin one test skip wrong");
  read_ctrl_a: assert property (ex && instr_i.op == OP_RD_ICA |=> acc_load_o &&
    acc_o == $past(irq_regs_o.irq_ctrl_reg_a)) else $error("control read wrong");
  write_ctrl_a: assert property (ex && instr_i.op == OP_WR_ICA |=>
    irq_regs_o.irq_ctrl_reg_a == $past(instr_i.acc)) else $error("control write wrong");
  read_timer_a: assert property (ex && instr_i.op == OP_RD_TCE |=> acc_load_o &&
    acc_o == $past(tmr_regs_o.timer_ctrl_reg_e)) else $error("timer read wrong");
  write_aux_a: assert property (ex && instr_i.op == OP_WR_AUX |=>
    tmr_regs_o.timer_aux_ctrl_reg == $past(instr_i.acc[1:0])) else $error("aux write wrong");
  skip_suppress_a: assert property (instr_i.valid && live |=> !acc_load_o && !skip_o &&
    $stable(irq_regs_o) && $stable(tmr_regs_o) && $stable(global_irq_enable_flag_o))
    else $error("suppressed op had an effect");
  skip_c: cover property (ex && instr_i.op == OP_TST_PIN0 ##1 skip_o);
  supp_c: cover property (instr_i.valid && live);
  load_c: cover property (acc_load_o);
endmodule : itc_exec_sva
bind itc_exec itc_exec_sva itc_exec_sva_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .acc_o(acc_o),
  .acc_load_o(acc_load_o), .skip_o(skip_o), .ext_irq_pin_zero_i(ext_irq_pin_zero_i),
  .ext_irq_pin_one_i(ext_irq_pin_one_i), .global_irq_enable_flag_o(global_irq_enable_flag_o),
  .ext_zero_request_flag_o(ext_zero_request_flag_o),
  .ext_one_request_flag_o(ext_one_request_flag_o), .irq_regs_o(irq_regs_o),
  .tmr_regs_o(tmr_regs_o));
`default_nettype wire

//--- bench/itc_seq_model.sv
// Sequencer and accumulator model that issues ops to the execution unit
`timescale 1ns/1ps
`default_nettype none
module itc_seq_model
  import itc_pkg::*;
(
  // Clock
  input  wire logic             ref_clk_i,
  // Answer from the unit
  input  wire logic [ACC_W-1:0] acc_i,
  input  wire logic             acc_load_i,
  input  wire logic             skip_i,
  // Request to the unit
  output var  itc_instr_t       instr_o
);
  logic [ACC_W-1:0] acc_reg = 4'h0;
  int               skip_cnt = 0;
  initial instr_o = '0;
  // Accumulator loads and skip requests taken at each edge
  always @(posedge ref_clk_i) begin
    if (acc_load_i === 1'b1) acc_reg <= acc_i;
    if (skip_i === 1'b1) skip_cnt <= skip_cnt + 1;
  end
  // Each op launches right after a rising edge; the last one drops valid and waits
  task automatic issue(input itc_op_t op, input logic [ACC_W-1:0] a, input bit last);
    @(posedge ref_clk_i);
    instr_o <= '{valid: 1'b1, op: op, acc: a};
    if (last) begin
      @(posedge ref_clk_i);
      instr_o <= '0;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
    end
  endtask : issue
endmodule : itc_seq_model
`default_nettype wire

//--- bench/test_irq_timer_ctrl_instr_exec.sv
// Self-checking bench for the interrupt and timer control execution unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_irq_timer_ctrl_instr_exec
  import itc_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] set_ev = 2'h0;
  logic [1:0] pin = 2'h0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, acc_load, skip, global_irq_enable_flag, f0, f1, irq;
  logic [WB_AW-1:0] wb_adr = '0;
  logic [3:0] wb_sel = 4'hF;
  logic [WB_DW-1:0] wb_wdat = '0, wb_rdat, rd;
  logic [ACC_W-1:0] acc;
  itc_instr_t instr;
  itc_irq_regs_t iregs;
  itc_tmr_regs_t tregs;
  int checked = 0, bad_count = 0, cyc_cnt = 0;
  itc_op_t wr_ops[8] = '{OP_WR_ICA, OP_WR_ICB, OP_WR_IPA, OP_WR_IPB,
                         OP_WR_TCA, OP_WR_TCB, OP_WR_TCC, OP_WR_TCE};
  itc_op_t rd_ops[8] = '{OP_RD_ICA, OP_RD_ICB, OP_RD_IPA, OP_RD_IPB,
                         OP_RD_TCA, OP_RD_TCB, OP_RD_TCC, OP_RD_TCE};
  itc_exec itc_exec_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_i(instr),
    .acc_o(acc), .acc_load_o(acc_load), .skip_o(skip), .ext_zero_req_set_i(set_ev[0]),
    .ext_one_req_set_i(set_ev[1]), .ext_irq_pin_zero_i(pin[0]), .ext_irq_pin_one_i(pin[1]),
    .global_irq_enable_flag_o(global_irq_enable_flag), .ext_zero_request_flag_o(f0),
    .ext_one_request_flag_o(f1), .irq_regs_o(iregs), .tmr_regs_o(tregs), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq));
  itc_seq_model itc_seq_model_inst (.ref_clk_i(ref_clk_i), .acc_i(acc), .acc_load_i(acc_load),
    .skip_i(skip), .instr_o(instr));
  // Clock and hang guard
  initial forever #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [WB_AW-1:0] adr, input logic [WB_DW-1:0] wd);
    @(posedge ref_clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    do @(posedge ref_clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wb_xfer
  task automatic op(input itc_op_t o, input logic [ACC_W-1:0] a);
    itc_seq_model_inst.issue(o, a, 1);
  endtask : op
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    set_ev[k] <= 1'b1;
    @(posedge ref_clk_i);
    set_ev[k] <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask : pulse
  // Test op, count skips, then a filler op to use up any skip
  task automatic tst(input itc_op_t o, input bit exp);
    int n;
    n = itc_seq_model_inst.skip_cnt;
    op(o, 4'h0);
    `CHK("skip taken", n + int'(exp), itc_seq_model_inst.skip_cnt)
    op(OP_NOP, 4'h0);
  endtask : tst
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(negedge ref_clk_i);
    op(OP_IRQ_EN, 4'h0);
    `CHK("enable", 1'b1, global_irq_enable_flag)
    op(OP_IRQ_DIS, 4'h0);
    `CHK("enable", 1'b0, global_irq_enable_flag)
    for (int i = 0; i < 8; i++) op(wr_ops[i], 4'(i * 3 + 2));
    op(OP_WR_AUX, 4'hE);
    for (int i = 0; i < 8; i++) begin
      op(rd_ops[i], 4'h0);
      `CHK("read back", 4'(i * 3 + 2), itc_seq_model_inst.acc_reg)
    end
    wb_xfer(1'b0, ADDR_IREGS, '0);
    `CHK("irq regs", 32'h0000_258B, rd)
    wb_xfer(1'b0, ADDR_TREGS, '0);
    `CHK("timer regs", 32'h0002_E147, rd)
    wb_xfer(1'b1, 8'h20, 32'h0000_FFFF);
    wb_xfer(1'b0, 8'h20, '0);
    `CHK("unmapped", 32'h0000_0000, rd)
    op(OP_WR_ICA, 4'h0);
    wb_xfer(1'b1, ADDR_IMASK, 32'h0000_0001);
    wb_sel <= 4'hE;
    wb_xfer(1'b1, ADDR_IMASK, 32'h0000_000F);
    wb_sel <= 4'hF;
    wb_xfer(1'b0, ADDR_IMASK, '0);
    `CHK("mask", 32'h0000_0001, rd)
    for (int k = 0; k < 2; k++) begin
      wb_xfer(1'b0, ADDR_ISTAT, '0);
      pulse(k);
      `CHK("flag set", 2'(1 << k), {f1, f0})
      `CHK("irq", 1'(k == 0), irq)
      wb_xfer(1'b0, ADDR_STATE, '0);
      `CHK("state", 32'(2 << k), rd)
      tst(k ? OP_TST_FLG1 : OP_TST_FLG0, 1'b1);
      `CHK("flag clear", 2'h0, {f1, f0})
      tst(k ? OP_TST_FLG1 : OP_TST_FLG0, 1'b0);
      op(OP_WR_ICA, 4'(1 << k));
      pulse(k);
      tst(k ? OP_TST_FLG1 : OP_TST_FLG0, 1'b0);
      `CHK("flag kept", 2'(1 << k), {f1, f0})
      op(OP_WR_ICA, 4'h0);
      tst(k ? OP_TST_FLG1 : OP_TST_FLG0, 1'b1);
    end
    wb_xfer(1'b0, ADDR_ISTAT, '0);
    `CHK("status", 32'h0000_000E, rd)
    wb_xfer(1'b0, ADDR_ISTAT, '0);
    `CHK("status cleared", 32'h0000_0000, rd)
    `CHK("irq cleared", 1'b0, irq)
    for (int c = 0; c < 8; c++) begin
      op(c[2] ? OP_WR_IPB : OP_WR_IPA, {1'b0, c[1], 2'b00});
      @(posedge ref_clk_i);
      pin[c[2]] <= c[0];
      repeat (4) @(negedge ref_clk_i);
      tst(c[2] ? OP_TST_PIN1 : OP_TST_PIN0, c[0] == c[1]);
    end
    op(OP_WR_IPA, 4'h0);
    @(posedge ref_clk_i);
    pin <= 2'h0;
    repeat (4) @(negedge ref_clk_i);
    wb_xfer(1'b0, ADDR_ISTAT, '0);
    itc_seq_model_inst.issue(OP_TST_PIN0, 4'h0, 0);
    itc_seq_model_inst.issue(OP_IRQ_EN, 4'h0, 1);
    `CHK("suppressed enable", 1'b0, global_irq_enable_flag)
    op(OP_TST_PIN0, 4'h0);
    repeat (3) @(negedge ref_clk_i);
    op(OP_WR_ICB, 4'hF);
    op(OP_RD_ICB, 4'h0);
    `CHK("suppressed write", 4'h5, itc_seq_model_inst.acc_reg)
    wb_xfer(1'b0, ADDR_ISTAT, '0);
    `CHK("skip status", 32'h0000_000C, rd)
    report_and_stop();
  end
endmodule : test_irq_timer_ctrl_instr_exec
`default_nettype wire
